// ===== inc/mbx_pkg.sv
// Constants for the move and bit-operation execute unit
//------------------------------------------------------------
// Overview of operation
// (RULE1) Indirect load reads data byte, two cycles
// (RULE2) Program byte to first register, three cycles
// (RULE3) I/O bit set, others kept, two cycles
// (RULE4) I/O bit clear, others kept, two cycles
// (RULE5) Left shift, zero in, Z C N V
// (RULE6) Right shift, zero into bit seven
// (RULE7) Arithmetic right shift keeps top bit
// (RULE8) Rotate left through carry, flags updated
// (RULE9) Rotate right through carry, one cycle
// (RULE10) Nibble swap, flags untouched, one cycle
// (RULE11) Register bit copied into transfer flag
// (RULE12) Transfer flag written into register bit
// (RULE13) Overflow flag set or cleared alone
// (RULE14) Half-carry flag set or cleared alone
// (RULE15) Signed-test flag set or cleared alone
// (RULE16) Generic flag op touches indexed bit only
//------------------------------------------------------------
package mbx_pkg;

  // Control registers, byte addresses
  localparam logic [11:0] ADDR_CMD   = 12'h000;
  localparam logic [11:0] ADDR_STAT  = 12'h004;
  localparam logic [11:0] ADDR_FLAGS = 12'h008;
  localparam logic [11:0] ADDR_PTR   = 12'h00c;
  // Windows selected by address bits 11:8
  localparam logic [3:0] RGN_CSR  = 4'h0;
  localparam logic [3:0] RGN_GPR  = 4'h1;
  localparam logic [3:0] RGN_IO   = 4'h2;
  localparam logic [3:0] RGN_DMEM = 4'h3;
  localparam logic [3:0] RGN_PMEM = 4'h4;
  // Memory address widths
  localparam int unsigned GPR_AW = 5;
  localparam int unsigned MEM_AW = 6;
  localparam logic [4:0]  GPR_FIRST = 5'h00;
  // Command word fields
  localparam int unsigned CMD_OP_LSB  = 0;
  localparam int unsigned CMD_RD_LSB  = 5;
  localparam int unsigned CMD_BIT_LSB = 10;
  localparam int unsigned CMD_IO_LSB  = 13;
  // Opcodes
  localparam logic [4:0] OP_NOP                  = 5'h00;
  localparam logic [4:0] OP_INDIRECT_LOAD        = 5'h01;
  localparam logic [4:0] OP_PROGRAM_MEMORY_READ  = 5'h02;
  localparam logic [4:0] OP_IO_BIT_SET           = 5'h03;
  localparam logic [4:0] OP_IO_BIT_CLEAR         = 5'h04;
  localparam logic [4:0] OP_SHIFT_LEFT_LOGICAL   = 5'h05;
  localparam logic [4:0] OP_SHIFT_RIGHT_LOGICAL  = 5'h06;
  localparam logic [4:0] OP_ARITH_SHIFT_RIGHT    = 5'h07;
  localparam logic [4:0] OP_ROTATE_LEFT_CARRY    = 5'h08;
  localparam logic [4:0] OP_ROTATE_RIGHT_CARRY   = 5'h09;
  localparam logic [4:0] OP_NIBBLE_SWAP          = 5'h0a;
  localparam logic [4:0] OP_BIT_TO_TRANSFER_FLAG = 5'h0b;
  localparam logic [4:0] OP_TRANSFER_FLAG_TO_BIT = 5'h0c;
  localparam logic [4:0] OP_FLAG_SET             = 5'h0d;
  localparam logic [4:0] OP_FLAG_CLEAR           = 5'h0e;
  localparam logic [4:0] OP_SET_OVERFLOW         = 5'h0f;
  localparam logic [4:0] OP_CLR_OVERFLOW         = 5'h10;
  localparam logic [4:0] OP_SET_HALF_CARRY       = 5'h11;
  localparam logic [4:0] OP_CLR_HALF_CARRY       = 5'h12;
  localparam logic [4:0] OP_SET_SIGNED           = 5'h13;
  localparam logic [4:0] OP_CLR_SIGNED           = 5'h14;
  // Status register flag positions
  localparam logic [2:0] FLG_C = 3'h0;
  localparam logic [2:0] FLG_Z = 3'h1;
  localparam logic [2:0] FLG_N = 3'h2;
  localparam logic [2:0] FLG_V = 3'h3;
  localparam logic [2:0] FLG_S = 3'h4;
  localparam logic [2:0] FLG_H = 3'h5;
  localparam logic [2:0] FLG_T = 3'h6;
  // Execute cycle counts
  localparam logic [1:0] CYC_LOAD  = 2'h2;
  localparam logic [1:0] CYC_PMEM  = 2'h3;
  localparam logic [1:0] CYC_IOBIT = 2'h2;
  localparam logic [1:0] CYC_ONE   = 2'h1;
  // Values after reset
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] PTR_RST   = 8'h00;
  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : mbx_pkg

// ===== core/mbx_mem.sv
// Byte-wide memory with registered read data
`timescale 1ns/1ps
`default_nettype none

module mbx_mem
  import mbx_pkg::*;
#(
  parameter int unsigned AW = 6
) (
  // Clock and reset
  input  wire logic          clk_in,
  input  wire logic          rst_in,
  // Write port
  input  wire logic          we_in,
  input  wire logic [AW-1:0] waddr_in,
  input  wire logic [7:0]    wdata_in,
  // Read port
  input  wire logic [AW-1:0] raddr_in,
  output logic      [7:0]    rdata_out
);

  logic [7:0] mem_q [0:(1<<AW)-1];

  // Array has no reset, so it maps onto plain RAM
  always_ff @(posedge clk_in) begin
    if (we_in) begin
      mem_q[waddr_in] <= wdata_in;
    end
  end

  // Read data one cycle after the address; old data on collision
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_out <= 8'h00;
    end else begin
      rdata_out <= mem_q[raddr_in];
    end
  end

endmodule : mbx_mem

`default_nettype wire

// ===== core/mbx_shift.sv
// Shift, rotate and nibble-swap datapath
`timescale 1ns/1ps
`default_nettype none

module mbx_shift
  import mbx_pkg::*;
(
  // Operation select
  input  wire logic [4:0] op_in,
  // Operand and carry
  input  wire logic [7:0] opnd_in,
  input  wire logic       carry_in,
  // Result and carry out
  output logic      [7:0] res_out,
  output logic            carry_out
);

  // Purely combinational; the caller decides when to write back
  always_comb begin
    res_out   = opnd_in;
    carry_out = carry_in;
    unique case (op_in)
      OP_SHIFT_LEFT_LOGICAL: begin
        res_out   = {opnd_in[6:0], 1'b0};           // [RULE5]
        carry_out = opnd_in[7];
      end
      OP_SHIFT_RIGHT_LOGICAL: begin
        res_out   = {1'b0, opnd_in[7:1]};           // [RULE6]
        carry_out = opnd_in[0];
      end
      OP_ARITH_SHIFT_RIGHT: begin
        res_out   = {opnd_in[7], opnd_in[7:1]};     // [RULE7]
        carry_out = opnd_in[0];
      end
      OP_ROTATE_LEFT_CARRY: begin
        res_out   = {opnd_in[6:0], carry_in};       // [RULE8]
        carry_out = opnd_in[7];
      end
      OP_ROTATE_RIGHT_CARRY: begin
        res_out   = {carry_in, opnd_in[7:1]};       // [RULE9]
        carry_out = opnd_in[0];
      end
      OP_NIBBLE_SWAP: begin
        res_out   = {opnd_in[3:0], opnd_in[7:4]};   // [RULE10]
      end
      default: begin
      end
    endcase
  end

endmodule : mbx_shift

`default_nettype wire

// ===== core/mbx_exec_top.sv
// Move and bit-operation execute unit with its AXI4-Lite slave
`timescale 1ns/1ps
`default_nettype none

module mbx_exec_top
  import mbx_pkg::*;
(
  // Clock and reset
  input  wire logic        CLK_IN,
  input  wire logic        SYS_RST_IN,
  // Write address channel
  input  wire logic [11:0] AXI_AWADDR_IN,
  input  wire logic        AXI_AWVALID_IN,
  output logic             AXI_AWREADY_OUT,
  // Write data channel
  input  wire logic [31:0] AXI_WDATA_IN,
  input  wire logic [3:0]  AXI_WSTRB_IN,
  input  wire logic        AXI_WVALID_IN,
  output logic             AXI_WREADY_OUT,
  // Write response channel
  output logic [1:0]       AXI_BRESP_OUT,
  output logic             AXI_BVALID_OUT,
  input  wire logic        AXI_BREADY_IN,
  // Read address channel
  input  wire logic [11:0] AXI_ARADDR_IN,
  input  wire logic        AXI_ARVALID_IN,
  output logic             AXI_ARREADY_OUT,
  // Read data channel
  output logic [31:0]      AXI_RDATA_OUT,
  output logic [1:0]       AXI_RRESP_OUT,
  output logic             AXI_RVALID_OUT,
  input  wire logic        AXI_RREADY_IN,
  // Execution status
  output logic             BUSY_OUT,
  output logic             DONE_OUT,
  output logic [7:0]       FLAGS_OUT
);

  //----------------------------------------------------------
  // Declarations
  //----------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_EXEC} mbx_state_e;
  // Bus holding registers
  logic [11:0] aw_addr_q;
  logic        aw_full_q, w_full_q, bvalid_q, rvalid_q, rpend_q;
  logic [31:0] w_data_q, rdata_q;
  logic [3:0]  w_strb_q, rrgn_q;
  logic [1:0]  bresp_q, rresp_q;
  // Execute state
  mbx_state_e  state_q;
  logic [1:0]  cnt_q, cyc;
  logic [4:0]  op_q, rd_q;
  logic [2:0]  bit_q;
  logic [5:0]  io_q;
  logic [7:0]  flags_q, ptr_q, res_q, flags_d;
  logic        done_q, exec_last;
  // Decode
  logic [3:0]  wr_rgn;
  logic [11:0] wr_word;
  logic        wr_map, wr_mem, wr_go, wr_refuse, wr_ok;
  logic        ar_go, ar_mem, idle, cmd_start;
  logic [31:0] csr_rd;
  // Memory ports
  logic        gpr_we, io_we, dm_we, pm_we;
  logic [4:0]  gpr_wa, gpr_ra;
  logic [5:0]  io_wa, io_ra, mem_ra;
  logic [7:0]  gpr_wd, gpr_rd, io_wd, io_rd, dm_rd, pm_rd;
  // Execute datapath
  logic [7:0]  sh_res, mask, wb_data;
  logic        sh_c, wb_gpr, wb_io;
  // Only the control block and the four windows answer
  function automatic logic in_map(input logic [11:0] a);
    unique case (a[11:8])
      RGN_CSR:  in_map = (a[7:4] == 4'h0);
      RGN_GPR:  in_map = ~a[7];
      RGN_IO, RGN_DMEM, RGN_PMEM: in_map = 1'b1;
      default:  in_map = 1'b0;
    endcase
  endfunction : in_map
  //----------------------------------------------------------
  // Bus decode
  //----------------------------------------------------------
  // The execute unit owns the memory ports while busy, so a
  // memory write waits for idle instead of racing the unit
  assign idle      = (state_q == ST_IDLE);
  assign wr_rgn    = aw_addr_q[11:8];
  assign wr_word   = {aw_addr_q[11:2], 2'b00};
  assign wr_map    = in_map(aw_addr_q);
  assign wr_mem    = wr_map && (wr_rgn != RGN_CSR);
  assign wr_go     = aw_full_q && w_full_q && !bvalid_q
                     && !(wr_mem && !idle);
  assign wr_refuse = !wr_map || (!idle && !wr_mem && wr_word != ADDR_STAT);
  assign wr_ok     = wr_go && !wr_refuse && w_strb_q[0];
  assign cmd_start = wr_ok && (wr_word == ADDR_CMD);
  assign ar_mem    = in_map(AXI_ARADDR_IN)
                     && (AXI_ARADDR_IN[11:8] != RGN_CSR);
  assign ar_go     = AXI_ARVALID_IN && AXI_ARREADY_OUT;
  // Handshake outputs
  assign AXI_AWREADY_OUT = !aw_full_q;
  assign AXI_WREADY_OUT  = !w_full_q;
  assign AXI_ARREADY_OUT = !rvalid_q && !rpend_q && !(ar_mem && !idle);
  assign AXI_BVALID_OUT  = bvalid_q;
  assign AXI_BRESP_OUT   = bresp_q;
  assign AXI_RVALID_OUT  = rvalid_q;
  assign AXI_RDATA_OUT   = rdata_q;
  assign AXI_RRESP_OUT   = rresp_q;
  assign BUSY_OUT        = !idle;
  assign DONE_OUT        = done_q;
  assign FLAGS_OUT       = flags_q;
  //----------------------------------------------------------
  // Write channels
  //----------------------------------------------------------
  // Address and data are held independently, either may lead
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      aw_full_q <= 1'b0;
      aw_addr_q <= 12'h000;
    end else if (AXI_AWVALID_IN && !aw_full_q) begin
      aw_full_q <= 1'b1;
      aw_addr_q <= AXI_AWADDR_IN;
    end else if (wr_go) begin
      aw_full_q <= 1'b0;
    end
  end
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      w_full_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else if (AXI_WVALID_IN && !w_full_q) begin
      w_full_q <= 1'b1;
      w_data_q <= AXI_WDATA_IN;
      w_strb_q <= AXI_WSTRB_IN;
    end else if (wr_go) begin
      w_full_q <= 1'b0;
    end
  end
  // Response once both halves are in; busy control writes other than ADDR_STAT fail
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_refuse ? RESP_SLVERR : RESP_OKAY;
    end else if (AXI_BREADY_IN) begin
      bvalid_q <= 1'b0;
    end
  end
  //----------------------------------------------------------
  // Read channels
  //----------------------------------------------------------
  // Control reads answer from live state
  always_comb begin
    unique case ({AXI_ARADDR_IN[11:2], 2'b00})
      ADDR_CMD:   csr_rd = {13'h0000, io_q, bit_q, rd_q, op_q};
      ADDR_STAT:  csr_rd = {16'h0000, res_q, 7'h00, !idle};
      ADDR_FLAGS: csr_rd = {24'h00_0000, flags_q};
      ADDR_PTR:   csr_rd = {24'h00_0000, ptr_q};
      default:    csr_rd = 32'h0000_0000;
    endcase
  end
  // Window reads cost one more cycle for the registered RAM
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      rvalid_q <= 1'b0;
      rpend_q  <= 1'b0;
      rrgn_q   <= RGN_CSR;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= RESP_OKAY;
    end else if (ar_go && ar_mem) begin
      rpend_q <= 1'b1;
      rrgn_q  <= AXI_ARADDR_IN[11:8];
    end else if (ar_go) begin
      rvalid_q <= 1'b1;
      rdata_q  <= csr_rd;
      rresp_q  <= in_map(AXI_ARADDR_IN) ? RESP_OKAY : RESP_SLVERR;
    end else if (rpend_q) begin
      rpend_q  <= 1'b0;
      rvalid_q <= 1'b1;
      rresp_q  <= RESP_OKAY;
      unique case (rrgn_q)
        RGN_GPR:  rdata_q <= {24'h00_0000, gpr_rd};
        RGN_IO:   rdata_q <= {24'h00_0000, io_rd};
        RGN_DMEM: rdata_q <= {24'h00_0000, dm_rd};
        default:  rdata_q <= {24'h00_0000, pm_rd};
      endcase
    end else if (AXI_RREADY_IN) begin
      rvalid_q <= 1'b0;
    end
  end
  //----------------------------------------------------------
  // Control registers
  //----------------------------------------------------------
  // Command fields are latched only when a command starts
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      op_q  <= OP_NOP;
      rd_q  <= 5'h00;
      bit_q <= 3'h0;
      io_q  <= 6'h00;
    end else if (cmd_start) begin
      op_q  <= w_data_q[CMD_OP_LSB +: 5];
      rd_q  <= w_data_q[CMD_RD_LSB +: 5];
      bit_q <= w_data_q[CMD_BIT_LSB +: 3];
      io_q  <= w_data_q[CMD_IO_LSB +: 6];
    end
  end
  // Pointer steers indirect and program memory reads
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      ptr_q <= PTR_RST;
    end else if (wr_ok && wr_word == ADDR_PTR) begin
      ptr_q <= w_data_q[7:0];
    end
  end
  // Status register; software writes are refused while busy
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      flags_q <= FLAGS_RST;
    end else if (exec_last) begin
      flags_q <= flags_d;
    end else if (wr_ok && wr_word == ADDR_FLAGS) begin
      flags_q <= w_data_q[7:0];
    end
  end
  //----------------------------------------------------------
  // Execute sequencer
  //----------------------------------------------------------
  // Cycle count of each operation in the execute state
  always_comb begin
    unique case (op_q)
      OP_INDIRECT_LOAD:       cyc = CYC_LOAD;     // [RULE1]
      OP_PROGRAM_MEMORY_READ: cyc = CYC_PMEM;     // [RULE2]
      OP_IO_BIT_SET,
      OP_IO_BIT_CLEAR:        cyc = CYC_IOBIT;    // [RULE3] [RULE4]
      default:                cyc = CYC_ONE;
    endcase
  end
  // One fetch cycle lets the RAM present the operand
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      state_q <= ST_IDLE;
      cnt_q   <= 2'h0;
    end else begin
      unique case (state_q)
        ST_IDLE: if (cmd_start) state_q <= ST_FETCH;
        ST_FETCH: begin
          cnt_q   <= cyc - 2'h1;
          state_q <= ST_EXEC;
        end
        ST_EXEC: begin
          if (cnt_q == 2'h0) begin
            state_q <= ST_IDLE;
          end else begin
            cnt_q <= cnt_q - 2'h1;
          end
        end
      endcase
    end
  end
  assign exec_last = (state_q == ST_EXEC) && (cnt_q == 2'h0);
  // Completion pulse and last written byte
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      done_q <= 1'b0;
      res_q  <= 8'h00;
    end else begin
      done_q <= exec_last;
      if (exec_last && (wb_gpr || wb_io)) begin
        res_q <= wb_data;
      end
    end
  end

  //----------------------------------------------------------
  // Execute datapath
  //----------------------------------------------------------
  mbx_shift u_shift (.op_in(op_q), .opnd_in(gpr_rd),
    .carry_in(flags_q[FLG_C]), .res_out(sh_res), .carry_out(sh_c));
  // Write-back value and the new flags, taken on the last cycle
  always_comb begin
    mask    = 8'h01 << bit_q;
    wb_data = sh_res;
    wb_gpr  = 1'b0;
    wb_io   = 1'b0;
    flags_d = flags_q;
    unique case (op_q)
      OP_INDIRECT_LOAD: begin
        wb_gpr  = 1'b1;
        wb_data = dm_rd; // [RULE1]
      end
      OP_PROGRAM_MEMORY_READ: begin
        wb_gpr  = 1'b1;
        wb_data = pm_rd; // [RULE2]
      end
      OP_IO_BIT_SET: begin
        wb_io   = 1'b1;
        wb_data = io_rd | mask; // [RULE3]
      end
      OP_IO_BIT_CLEAR: begin
        wb_io   = 1'b1;
        wb_data = io_rd & ~mask; // [RULE4]
      end
      OP_SHIFT_LEFT_LOGICAL, OP_SHIFT_RIGHT_LOGICAL,
      OP_ARITH_SHIFT_RIGHT, OP_ROTATE_LEFT_CARRY,
      OP_ROTATE_RIGHT_CARRY: begin
        // Only Z, C, N and V move; S and H keep their value
        wb_gpr         = 1'b1;
        flags_d[FLG_C] = sh_c; // [RULE5] [RULE6] [RULE7]
        flags_d[FLG_Z] = (sh_res == 8'h00); // [RULE8]
        flags_d[FLG_N] = sh_res[7]; // [RULE9]
        flags_d[FLG_V] = sh_res[7] ^ sh_c;
      end
      OP_NIBBLE_SWAP:          wb_gpr = 1'b1; // [RULE10]
      OP_BIT_TO_TRANSFER_FLAG: flags_d[FLG_T] = gpr_rd[bit_q]; // [RULE11]
      OP_TRANSFER_FLAG_TO_BIT: begin
        wb_gpr  = 1'b1;
        wb_data = flags_q[FLG_T] ? (gpr_rd | mask)
                                 : (gpr_rd & ~mask); // [RULE12]
      end
      OP_FLAG_SET:       flags_d[bit_q] = 1'b1; // [RULE16]
      OP_FLAG_CLEAR:     flags_d[bit_q] = 1'b0; // [RULE16]
      OP_SET_OVERFLOW:   flags_d[FLG_V] = 1'b1; // [RULE13]
      OP_CLR_OVERFLOW:   flags_d[FLG_V] = 1'b0; // [RULE13]
      OP_SET_HALF_CARRY: flags_d[FLG_H] = 1'b1; // [RULE14]
      OP_CLR_HALF_CARRY: flags_d[FLG_H] = 1'b0; // [RULE14]
      OP_SET_SIGNED:     flags_d[FLG_S] = 1'b1; // [RULE15]
      OP_CLR_SIGNED:     flags_d[FLG_S] = 1'b0; // [RULE15]
      default: ;
    endcase
  end
  //----------------------------------------------------------
  // Memories
  //----------------------------------------------------------
  // Read addresses follow the bus when idle, the command or pointer when busy
  assign gpr_ra = idle ? AXI_ARADDR_IN[6:2] : rd_q;
  assign io_ra  = idle ? AXI_ARADDR_IN[7:2] : io_q;
  assign mem_ra = idle ? AXI_ARADDR_IN[7:2] : ptr_q[5:0];
  // Program memory read always lands in the first register
  assign gpr_we = (exec_last && wb_gpr) || (wr_ok && wr_rgn == RGN_GPR);
  assign gpr_wa = idle ? aw_addr_q[6:2]
                : (op_q == OP_PROGRAM_MEMORY_READ) ? GPR_FIRST
                : rd_q; // [RULE2]
  assign gpr_wd = idle ? w_data_q[7:0] : wb_data;
  assign io_we  = (exec_last && wb_io) || (wr_ok && wr_rgn == RGN_IO);
  assign io_wa  = idle ? aw_addr_q[7:2] : io_q;
  assign io_wd  = idle ? w_data_q[7:0] : wb_data;
  assign dm_we  = wr_ok && (wr_rgn == RGN_DMEM);
  assign pm_we  = wr_ok && (wr_rgn == RGN_PMEM);
  // Register file, I/O space, data memory, program memory
  mbx_mem #(.AW(GPR_AW)) u_gpr (.clk_in(CLK_IN), .rst_in(SYS_RST_IN),
    .we_in(gpr_we), .waddr_in(gpr_wa), .wdata_in(gpr_wd),
    .raddr_in(gpr_ra), .rdata_out(gpr_rd));
  mbx_mem #(.AW(MEM_AW)) u_io (.clk_in(CLK_IN), .rst_in(SYS_RST_IN),
    .we_in(io_we), .waddr_in(io_wa), .wdata_in(io_wd),
    .raddr_in(io_ra), .rdata_out(io_rd));
  mbx_mem #(.AW(MEM_AW)) u_dmem (.clk_in(CLK_IN), .rst_in(SYS_RST_IN),
    .we_in(dm_we), .waddr_in(aw_addr_q[7:2]), .wdata_in(w_data_q[7:0]),
    .raddr_in(mem_ra), .rdata_out(dm_rd));
  mbx_mem #(.AW(MEM_AW)) u_pmem (.clk_in(CLK_IN), .rst_in(SYS_RST_IN),
    .we_in(pm_we), .waddr_in(aw_addr_q[7:2]), .wdata_in(w_data_q[7:0]),
    .raddr_in(mem_ra), .rdata_out(pm_rd));
endmodule : mbx_exec_top

`default_nettype wire

// ===== verification/mbx_exec_assertions.sv
// Port-level checks for the move and bit-operation execute unit
`timescale 1ns/1ps
`default_nettype none
module mbx_exec_assertions
  import mbx_pkg::*;
(
  // Clock, reset, bus and status
  input wire logic        CLK_IN, SYS_RST_IN, AXI_ARVALID_IN, AXI_ARREADY_OUT,
  input wire logic        AXI_RVALID_OUT, AXI_RREADY_IN, AXI_BVALID_OUT,
  input wire logic        AXI_BREADY_IN, BUSY_OUT, DONE_OUT,
  input wire logic [11:0] AXI_ARADDR_IN,
  input wire logic [31:0] AXI_RDATA_OUT,
  input wire logic [1:0]  AXI_RRESP_OUT,
  input wire logic [7:0]  FLAGS_OUT
);
  //----------------------------------------------------------
  // Properties
  //----------------------------------------------------------
  // One domain, so one clocking and one reset serve every property
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  // Fetch plus at least one execute cycle, then a lone done
  sequence s_run; BUSY_OUT [*2]; endsequence
  sequence s_end; !BUSY_OUT && DONE_OUT; endsequence
  a_busy_span: assert property ($rose(BUSY_OUT) |-> s_run ##[1:3] s_end)
    else $error("busy span out of range");
  a_start_ack: assert property ($rose(BUSY_OUT) |-> $rose(AXI_BVALID_OUT))
    else $error("busy rose without write response");
  a_done_pulse: assert property (DONE_OUT |-> $past(BUSY_OUT) ##1 !DONE_OUT)
    else $error("done not one pulse after busy");
  // Flags may move only at the edge that ends a command or a write
  a_flags_run: assert property (BUSY_OUT && $past(BUSY_OUT) |-> $stable(FLAGS_OUT))
    else $error("flags moved during a command");
  a_flags_idle: assert property (!BUSY_OUT && !$past(BUSY_OUT)
    && !$rose(AXI_BVALID_OUT) |-> $stable(FLAGS_OUT))
    else $error("flags moved while idle");
  a_b_clear: assert property (AXI_BVALID_OUT && AXI_BREADY_IN |=> !AXI_BVALID_OUT)
    else $error("write response not retired");
  a_r_clear: assert property (AXI_RVALID_OUT && AXI_RREADY_IN |=> !AXI_RVALID_OUT)
    else $error("read response not retired");
  a_unmapped_rd: assert property (AXI_ARVALID_IN && AXI_ARREADY_OUT
    && AXI_ARADDR_IN[11:8] > RGN_PMEM |-> ##[1:2] AXI_RVALID_OUT
    && AXI_RRESP_OUT == RESP_SLVERR && AXI_RDATA_OUT == 32'h0)
    else $error("unmapped read not refused");
endmodule : mbx_exec_assertions
bind mbx_exec_top mbx_exec_assertions u_chk (.CLK_IN, .SYS_RST_IN,
  .AXI_ARVALID_IN, .AXI_ARREADY_OUT, .AXI_RVALID_OUT, .AXI_RREADY_IN,
  .AXI_BVALID_OUT, .AXI_BREADY_IN, .BUSY_OUT, .DONE_OUT, .AXI_ARADDR_IN,
  .AXI_RDATA_OUT, .AXI_RRESP_OUT, .FLAGS_OUT);
`default_nettype wire

// ===== verification/move_and_bit_op_execute_tb_top.sv
// Self-checking bench for the execute unit
`timescale 1ns/1ps
`default_nettype none
module move_and_bit_op_execute_tb_top;
  import mbx_pkg::*;
  logic        clk, rst, awv, wv, arv;
  logic [11:0] awa, ara;
  logic [31:0] wd;
  wire logic   awr, wr_rdy, bv, arr, rv, busy, done;
  wire logic [1:0]  br, rr;
  wire logic [31:0] rd;
  wire logic [7:0]  flg;
  int          errors, n_tests;
  // Ready lines stay high: always willing to take a response
  mbx_exec_top u_dut (.CLK_IN(clk), .SYS_RST_IN(rst), .AXI_AWADDR_IN(awa),
    .AXI_AWVALID_IN(awv), .AXI_AWREADY_OUT(awr), .AXI_WDATA_IN(wd),
    .AXI_WSTRB_IN(4'hf), .AXI_WVALID_IN(wv), .AXI_WREADY_OUT(wr_rdy),
    .AXI_BRESP_OUT(br), .AXI_BVALID_OUT(bv), .AXI_BREADY_IN(1'b1),
    .AXI_ARADDR_IN(ara), .AXI_ARVALID_IN(arv), .AXI_ARREADY_OUT(arr),
    .AXI_RDATA_OUT(rd), .AXI_RRESP_OUT(rr), .AXI_RVALID_OUT(rv),
    .AXI_RREADY_IN(1'b1), .BUSY_OUT(busy), .DONE_OUT(done), .FLAGS_OUT(flg));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  //----------------------------------------------------------
  // Helpers
  //----------------------------------------------------------
  task automatic chk(input logic [31:0] s, e);
    n_tests++;
    if (s !== e) begin
      errors++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1;
    forever begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr_rdy) wv <= 1'b0;
      if (bv) begin
        chk(br, RESP_OKAY);
        break;
      end
    end
  endtask : wr
  // Response code expected from the address window alone
  task automatic rdw(input logic [11:0] a, input logic [31:0] e);
    ara <= a; arv <= 1'b1;
    forever begin
      @(posedge clk);
      if (arv && arr) arv <= 1'b0;
      if (rv) begin
        chk(rd, e);
        chk(rr, a[11:8] > RGN_PMEM ? RESP_SLVERR : RESP_OKAY);
        break;
      end
    end
  endtask : rdw
  // Launch a command and count its busy cycles up to done
  task automatic ex(input logic [4:0] op, rg, input logic [2:0] b,
                    input logic [5:0] io, input int n);
    int c;
    c = 0;
    wr(ADDR_CMD, {13'h0, io, b, rg, op});
    while (done !== 1'b1 && c < 9) begin
      c += int'(busy);
      @(posedge clk);
    end
    chk(c, n + 1);
  endtask : ex
  function automatic logic [15:0] shx(input logic [4:0] o,
                                       input logic [7:0] v, f);
    logic [7:0] r;
    logic       c;
    c = f[FLG_C];
    r = {v[3:0], v[7:4]};
    case (o)
      OP_SHIFT_LEFT_LOGICAL:  {c, r} = {v, 1'b0};
      OP_SHIFT_RIGHT_LOGICAL: {r, c} = {1'b0, v};
      OP_ARITH_SHIFT_RIGHT:   {r, c} = {v[7], v};
      OP_ROTATE_LEFT_CARRY:   {c, r} = {v, f[FLG_C]};
      OP_ROTATE_RIGHT_CARRY:  {r, c} = {f[FLG_C], v};
      default: ;
    endcase
    if (o != OP_NIBBLE_SWAP) begin
      f[FLG_C] = c; f[FLG_Z] = (r == 8'h0); f[FLG_N] = r[7]; f[FLG_V] = r[7] ^ c;
    end
    return {f, r};
  endfunction : shx
  //----------------------------------------------------------
  // Scenarios
  //----------------------------------------------------------
  // Every shift kind, with a zero result and both carry values
  task automatic t_shift();
    logic [15:0] e;
    logic [7:0]  v, f;
    for (int i = 0; i < 2; i++)
      for (logic [4:0] o = OP_SHIFT_LEFT_LOGICAL; o <= OP_NIBBLE_SWAP; o++) begin
        v = i ? 8'h01 : 8'h81;
        f = i ? 8'h20 : 8'h31;
        e = shx(o, v, f);
        wr(ADDR_FLAGS, {24'h0, f});
        wr(12'h10c, {24'h0, v});
        ex(o, 5'h03, 3'h0, 6'h0, CYC_ONE);
        rdw(12'h10c, {24'h0, e[7:0]});
        rdw(ADDR_FLAGS, {24'h0, e[15:8]});
      end
  endtask : t_shift
  task automatic t_mem();
    wr(12'h3a8, 32'h5a);
    wr(ADDR_PTR, 32'h2a);
    wr(ADDR_FLAGS, 32'h7f);
    ex(OP_INDIRECT_LOAD, 5'h07, 3'h0, 6'h0, CYC_LOAD);
    rdw(12'h11c, 32'h5a);
    wr(12'h454, 32'ha6);
    wr(ADDR_PTR, 32'h15);
    ex(OP_PROGRAM_MEMORY_READ, 5'h09, 3'h0, 6'h0, CYC_PMEM);
    rdw(12'h100, 32'ha6);
    wr(12'h2fc, 32'h5a);
    ex(OP_IO_BIT_SET, 5'h00, 3'h7, 6'h3f, CYC_IOBIT);
    rdw(12'h2fc, 32'hda);
    ex(OP_IO_BIT_CLEAR, 5'h00, 3'h1, 6'h3f, CYC_IOBIT);
    rdw(12'h2fc, 32'hd8);
    rdw(ADDR_FLAGS, 32'h7f);
    rdw(12'hf00, 32'h0);
  endtask : t_mem
  task automatic t_bits();
    wr(ADDR_FLAGS, 32'h0);
    wr(12'h114, 32'h10);
    wr(12'h118, 32'h80);
    ex(OP_BIT_TO_TRANSFER_FLAG, 5'h05, 3'h4, 6'h0, CYC_ONE);
    rdw(ADDR_FLAGS, 32'h40);
    ex(OP_TRANSFER_FLAG_TO_BIT, 5'h06, 3'h0, 6'h0, CYC_ONE);
    rdw(12'h118, 32'h81);
    rdw(ADDR_FLAGS, 32'h40);
  endtask : t_bits
  // Generic index sweep, then the dedicated pairs over other set flags
  task automatic t_flag();
    logic [2:0] pos [3] = '{FLG_V, FLG_H, FLG_S};
    wr(ADDR_FLAGS, 32'h0);
    for (int b = 0; b < 8; b++) begin
      ex(OP_FLAG_SET, 5'h0, 3'(b), 6'h0, CYC_ONE);
      rdw(ADDR_FLAGS, 32'h1 << b);
      ex(OP_FLAG_CLEAR, 5'h0, 3'(b), 6'h0, CYC_ONE);
      rdw(ADDR_FLAGS, 32'h0);
    end
    wr(ADDR_FLAGS, 32'h47);
    for (int k = 0; k < 3; k++) begin
      ex(OP_SET_OVERFLOW + 5'(2 * k), 5'h0, 3'h0, 6'h0, CYC_ONE);
      rdw(ADDR_FLAGS, 32'h47 | (32'h1 << pos[k]));
      ex(OP_CLR_OVERFLOW + 5'(2 * k), 5'h0, 3'h0, 6'h0, CYC_ONE);
      rdw(ADDR_FLAGS, 32'h47);
    end
  endtask : t_flag
  task automatic report_and_stop();
    if (errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  initial begin
    rst = 1'b1; awv = 1'b0; wv = 1'b0; arv = 1'b0;
    awa = 12'h0; ara = 12'h0; wd = 32'h0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_shift();
    t_mem();
    t_bits();
    t_flag();
    report_and_stop();
  end
  // Whole run is about five hundred cycles; 20000 cycles means a hang
  initial begin
    #400000;
    errors++;
    report_and_stop();
  end
endmodule : move_and_bit_op_execute_tb_top
`default_nettype wire
